// File: logic/hfpa_top.sv
// Contract
// R01: writes to read-only locations change nothing and cause no side effect.
// R02: reads of write-only locations return zero.
// R03: write-one-to-clear bits clear on a written one, ignore a zero.
// R04: clear-on-read bits return their value, then clear.
// R05: latching flags hold until their register is read, then release.
// R06: soft-reset-immune bits keep their value across a software reset.
// R07: host writes zeros to reserved fields and ignores their read value.
// R08: reserved locations may read any value; here they read zero.
// R09: host never writes reserved locations.
// R10: every reset source loads configuration registers with defaults; a software reset here keeps mode16 and loads only the capacities.
// R11: four fifos; data and receive-status capacities set by register.
// R12: receive-status pop port returns oldest entry and removes it.
// R13: receive-status view port returns oldest entry, fifo unchanged.
// R14: receive data fifo reads always pop.
// R15: all eight receive data aliases at 00h..1Ch pop the same fifo.
// R16: transmit-status pop port returns oldest entry and removes it.
// R17: transmit-status view port returns oldest entry, fifo unchanged.
// R18: transmit data aliases at 20h..3Ch all push the same fifo.
// R19: popping an empty fifo leaves its pointers untouched.
// R20: split 16-bit accesses move pointers exactly once per word.
`timescale 1ns/10ps
module hfpa_top #(
	parameter int AW = hfpa_pkg::FIFO_AW
) (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic                        softRstReq,
	// host port
	input  wire logic [7:0]                  hostAddr,
	input  wire logic                        hostRd,
	input  wire logic                        hostWr,
	input  wire logic [hfpa_pkg::DATA_W-1:0] hostWrData,
	output logic      [hfpa_pkg::DATA_W-1:0] hostRdData,
	output logic                             hostRdValid,
	// datapath side
	input  wire logic                        rxDataPush,
	input  wire logic [hfpa_pkg::DATA_W-1:0] rxDataIn,
	input  wire logic                        rxStsPush,
	input  wire logic [hfpa_pkg::DATA_W-1:0] rxStsIn,
	input  wire logic                        txStsPush,
	input  wire logic [hfpa_pkg::DATA_W-1:0] txStsIn,
	input  wire logic                        txDataPop,
	output logic      [hfpa_pkg::DATA_W-1:0] txDataOut,
	output logic                             txDataValid,
	// fill levels
	output logic      [AW:0]                 rxDataLevel,
	output logic      [AW:0]                 rxStsLevel,
	output logic      [AW:0]                 txStsLevel,
	output logic      [AW:0]                 txDataLevel
);
	localparam int         DW       = hfpa_pkg::DATA_W;
	localparam logic [AW:0] FULL_CAP = {1'b1, {AW{1'b0}}};

	typedef struct packed {
		logic [3:0][AW-1:0]  head;
		logic [3:0][AW-1:0]  tail;
		logic [3:0][AW:0]    cnt;
		logic [AW:0]         capRxd;
		logic [AW:0]         capRxs;
		logic [AW:0]         capTxd;
		logic                mode16;
		logic                rxUnder;
		logic                txOver;
		logic                rxOver;
		logic                stsFullSeen;
		logic                txSpaceOk;
		logic [7:0]          dropCnt;
		logic                pendValid;
		hfpa_pkg::hfpa_src_t pendSrc;
		logic [1:0]          pendFifo;
		logic                pendEmpty;
		logic                pendHalfHi;
		logic [DW-1:0]       pendReg;
		logic [15:0]         rdHold;
		logic [15:0]         wrHold;
		logic                txPendValid;
		logic                txPendEmpty;
		logic [DW-1:0]       rdData;
		logic                rdValid;
		logic [DW-1:0]       txOut;
		logic                txValid;
	} hfpa_state_t;

	function automatic hfpa_state_t defState();
		hfpa_state_t d;
		d           = '0;
		d.capRxd    = FULL_CAP;
		d.capRxs    = FULL_CAP;
		d.capTxd    = FULL_CAP;
		d.mode16    = hfpa_pkg::CFG_MODE16_RST;
		d.txSpaceOk = hfpa_pkg::EVT_SPACE_RST;
		return d;
	endfunction : defState

	function automatic logic isFull(logic [AW:0] c, logic [AW:0] cap);
		return (c >= cap) || c[AW];
	endfunction : isFull

	hfpa_state_t          s;
	hfpa_state_t          n;
	logic [3:0]           pop;
	logic [3:0]           push;
	logic [3:0][DW-1:0]   memWrData;
	logic [3:0][DW-1:0]   memRd;
	logic [7:0]           base;
	logic                 halfHi;
	logic [DW-1:0]        wrMask;
	logic [DW-1:0]        wrWord;
	logic [DW-1:0]        word;
	logic [DW-1:0]        regCap;
	logic [DW-1:0]        regCfg;
	logic [DW-1:0]        regEvt;
	logic [DW-1:0]        regLvl;
	logic [DW-1:0]        merged;
	logic [DW-1:0]        txWord;
	logic [1:0]           fsel;
	logic                 fifoHit;
	logic                 doPop;
	logic                 evtRead;
	logic                 hostUnder;
	logic                 txOverSet;
	logic                 rxOverSet;
	logic                 softClr;
	logic                 keepMode;
	logic                 keepValid;
	logic [DW-1:0]        keepData;

	always_comb begin
		n           = s;
		n.rdValid   = 1'b0;
		n.txValid   = 1'b0;
		n.pendValid = 1'b0;
		n.txPendValid = 1'b0;
		pop       = '0;
		push      = '0;
		memWrData = '0;
		word      = '0;
		merged    = '0;
		txWord    = '0;
		fsel      = hfpa_pkg::FIFO_RXD;
		fifoHit   = 1'b0;
		doPop     = 1'b0;
		evtRead   = 1'b0;
		hostUnder = 1'b0;
		txOverSet = 1'b0;
		rxOverSet = 1'b0;
		softClr   = softRstReq;
		base      = {hostAddr[7:2], 2'b00};
		halfHi    = s.mode16 & hostAddr[1];
		wrMask    = !s.mode16 ? hfpa_pkg::MASK_ALL :
			(hostAddr[1] ? hfpa_pkg::MASK_HI : hfpa_pkg::MASK_LO);
		wrWord    = !s.mode16 ? hostWrData :
			(hostAddr[1] ? {hostWrData[15:0], 16'h0000} :
			{16'h0000, hostWrData[15:0]});

		// register views
		regCap = '0;
		regCap[hfpa_pkg::CAP_RXD_POS +: AW+1] = s.capRxd;
		regCap[hfpa_pkg::CAP_RXS_POS +: AW+1] = s.capRxs;
		regCap[hfpa_pkg::CAP_TXD_POS +: AW+1] = s.capTxd;
		regCfg = '0;
		regCfg[hfpa_pkg::CFG_MODE16_BIT] = s.mode16;
		regEvt = '0;
		regEvt[hfpa_pkg::EVT_RX_UNDER] = s.rxUnder;
		regEvt[hfpa_pkg::EVT_TX_OVER]  = s.txOver;
		regEvt[hfpa_pkg::EVT_RX_OVER]  = s.rxOver;
		regEvt[hfpa_pkg::EVT_STS_FULL] = s.stsFullSeen;
		regEvt[hfpa_pkg::EVT_TX_SPACE] = s.txSpaceOk;
		regEvt[hfpa_pkg::EVT_DROP_POS +: 8] = s.dropCnt;
		regLvl = '0;
		regLvl[hfpa_pkg::LVL_RXD_POS +: AW+1] = s.cnt[hfpa_pkg::FIFO_RXD];
		regLvl[hfpa_pkg::LVL_RXS_POS +: AW+1] = s.cnt[hfpa_pkg::FIFO_RXS];
		regLvl[hfpa_pkg::LVL_TXS_POS +: AW+1] = s.cnt[hfpa_pkg::FIFO_TXS];
		regLvl[hfpa_pkg::LVL_TXD_POS +: AW+1] = s.cnt[hfpa_pkg::FIFO_TXD];

		// answer stage: storage data arrives one cycle after the request
		if (s.pendValid) begin
			word = s.pendReg;
			if (s.pendSrc == hfpa_pkg::SRC_MEM)
				word = s.pendEmpty ? '0 : memRd[s.pendFifo];
			if (s.mode16) begin
				if (s.pendSrc == hfpa_pkg::SRC_MEM && !s.pendHalfHi)
					n.rdHold = word[31:16]; // R20
				n.rdData = {16'h0000,
					s.pendHalfHi ? word[31:16] : word[15:0]};
			end else begin
				n.rdData = word;
			end
			n.rdValid = 1'b1;
		end
		if (s.txPendValid) begin
			n.txOut   = s.txPendEmpty ? '0 : memRd[hfpa_pkg::FIFO_TXD];
			n.txValid = !s.txPendEmpty;
		end

		// host read takes priority over a simultaneous write
		if (hostRd) begin
			n.pendValid  = 1'b1;
			n.pendHalfHi = halfHi;
			n.pendSrc    = hfpa_pkg::SRC_REG;
			n.pendReg    = '0;
			n.pendEmpty  = 1'b0;
			if (base <= hfpa_pkg::OFF_RXD_HI) begin
				fifoHit = 1'b1; // R15
				fsel    = hfpa_pkg::FIFO_RXD;
				doPop   = 1'b1; // R14
			end else begin
				case (base)
					hfpa_pkg::OFF_RXS_POP: begin
						fifoHit = 1'b1;
						fsel    = hfpa_pkg::FIFO_RXS;
						doPop   = 1'b1; // R12
					end
					hfpa_pkg::OFF_RXS_NONDESTRUCTIVE_VIEW_PORT: begin
						fifoHit = 1'b1; // R13
						fsel    = hfpa_pkg::FIFO_RXS;
					end
					hfpa_pkg::OFF_TXS_POP: begin
						fifoHit = 1'b1;
						fsel    = hfpa_pkg::FIFO_TXS;
						doPop   = 1'b1; // R16
					end
					hfpa_pkg::OFF_TXS_NONDESTRUCTIVE_VIEW_PORT: begin
						fifoHit = 1'b1; // R17
						fsel    = hfpa_pkg::FIFO_TXS;
					end
					hfpa_pkg::OFF_CAP: n.pendReg = regCap;
					hfpa_pkg::OFF_CFG: n.pendReg = regCfg;
					hfpa_pkg::OFF_EVT: begin
						n.pendReg = regEvt;
						evtRead   = 1'b1; // R04 R05
					end
					hfpa_pkg::OFF_LVL: n.pendReg = regLvl;
					// write-only data window and reserved space
					default: n.pendReg = '0; // R02 R08
				endcase
			end
			if (fifoHit) begin
				if (doPop && halfHi) begin
					// upper half of a word already popped; a low half
					// answered this very cycle has not reached rdHold yet
					n.pendReg = {(s.pendValid && !s.pendHalfHi &&
						s.pendSrc == hfpa_pkg::SRC_MEM && s.pendFifo == fsel) ?
						word[31:16] : s.rdHold, 16'h0000}; // R20
				end else begin
					n.pendSrc   = hfpa_pkg::SRC_MEM;
					n.pendFifo  = fsel;
					n.pendEmpty = s.cnt[fsel] == '0;
					if (doPop) begin
						if (s.cnt[fsel] == '0)
							hostUnder = 1'b1; // R19
						else
							pop[fsel] = 1'b1;
					end
				end
			end
		end else if (hostWr) begin
			if (base >= hfpa_pkg::OFF_TXD_LO && base <= hfpa_pkg::OFF_TXD_HI)
			begin
				if (s.mode16 && !hostAddr[1]) begin
					n.wrHold = hostWrData[15:0]; // R20
				end else begin
					txWord = s.mode16 ? {hostWrData[15:0], s.wrHold}
						: hostWrData; // R18
					if (isFull(s.cnt[hfpa_pkg::FIFO_TXD], s.capTxd)) begin
						txOverSet = 1'b1;
					end else begin
						push[hfpa_pkg::FIFO_TXD]      = 1'b1;
						memWrData[hfpa_pkg::FIFO_TXD] = txWord;
					end
				end
			end else begin
				case (base)
					hfpa_pkg::OFF_CAP: begin
						merged   = (regCap & ~wrMask) | (wrWord & wrMask);
						n.capRxd = merged[hfpa_pkg::CAP_RXD_POS +: AW+1]; // R11
						n.capRxs = merged[hfpa_pkg::CAP_RXS_POS +: AW+1];
						n.capTxd = merged[hfpa_pkg::CAP_TXD_POS +: AW+1];
					end
					hfpa_pkg::OFF_CFG: begin
						if (wrMask[hfpa_pkg::CFG_MODE16_BIT])
							n.mode16 = wrWord[hfpa_pkg::CFG_MODE16_BIT];
						// self-clearing: never stored
						if (wrMask[hfpa_pkg::CFG_SWRST_BIT] &&
							wrWord[hfpa_pkg::CFG_SWRST_BIT])
							softClr = 1'b1;
					end
					hfpa_pkg::OFF_EVT: begin
						merged = wrWord & wrMask;
						if (merged[hfpa_pkg::EVT_RX_UNDER])
							n.rxUnder = 1'b0; // R03
						if (merged[hfpa_pkg::EVT_TX_OVER])
							n.txOver = 1'b0; // R03
						if (merged[hfpa_pkg::EVT_RX_OVER])
							n.rxOver = 1'b0; // R03
					end
					// status ports, levels, receive window, reserved
					default: ; // R01 R09
				endcase
			end
		end

		// datapath side; a push into a full fifo is dropped, and counted only for the two receive fifos
		if (rxDataPush) begin
			if (isFull(s.cnt[hfpa_pkg::FIFO_RXD], s.capRxd)) begin
				rxOverSet = 1'b1;
			end else begin
				push[hfpa_pkg::FIFO_RXD]      = 1'b1;
				memWrData[hfpa_pkg::FIFO_RXD] = rxDataIn;
			end
		end
		if (rxStsPush) begin
			if (isFull(s.cnt[hfpa_pkg::FIFO_RXS], s.capRxs)) begin
				rxOverSet = 1'b1;
			end else begin
				push[hfpa_pkg::FIFO_RXS]      = 1'b1;
				memWrData[hfpa_pkg::FIFO_RXS] = rxStsIn;
			end
		end
		if (txStsPush && !isFull(s.cnt[hfpa_pkg::FIFO_TXS], FULL_CAP)) begin
			push[hfpa_pkg::FIFO_TXS]      = 1'b1;
			memWrData[hfpa_pkg::FIFO_TXS] = txStsIn;
		end
		if (txDataPop) begin
			n.txPendValid = 1'b1;
			n.txPendEmpty = s.cnt[hfpa_pkg::FIFO_TXD] == '0;
			pop[hfpa_pkg::FIFO_TXD] = s.cnt[hfpa_pkg::FIFO_TXD] != '0; // R19
		end

		for (int i = 0; i < 4; i++) begin
			n.head[i] = s.head[i] + AW'(pop[i]);
			n.tail[i] = s.tail[i] + AW'(push[i]);
			n.cnt[i]  = s.cnt[i] + (AW+1)'(push[i]) - (AW+1)'(pop[i]);
		end

		// releases first so that a same-cycle event wins
		if (evtRead) begin
			n.dropCnt     = '0; // R04
			n.stsFullSeen = 1'b0; // R05
			n.txSpaceOk   = 1'b1; // R05
		end
		if (hostUnder)
			n.rxUnder = 1'b1;
		if (txOverSet)
			n.txOver = 1'b1;
		if (rxOverSet) begin
			n.rxOver = 1'b1;
			if (n.dropCnt != hfpa_pkg::DROP_MAX)
				n.dropCnt = n.dropCnt + 8'h01;
		end
		if (isFull(n.cnt[hfpa_pkg::FIFO_RXS], s.capRxs))
			n.stsFullSeen = 1'b1; // R05
		if (isFull(n.cnt[hfpa_pkg::FIFO_TXD], s.capTxd))
			n.txSpaceOk = 1'b0; // R05

		// an in-flight read answer still completes across a soft reset
		keepMode  = n.mode16;
		keepValid = n.rdValid;
		keepData  = n.rdData;
		if (softClr) begin
			n         = defState(); // R10
			n.mode16  = keepMode; // R06
			n.rdValid = keepValid;
			n.rdData  = keepData;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			s <= defState(); // R10
		else
			s <= n;
	end

	// one storage block per fifo
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gFifo
			hfpa_mem_if #(.W(DW), .AW(AW)) mif ();
			assign mif.wrEn   = push[g];
			assign mif.wrAddr = s.tail[g];
			assign mif.wrData = memWrData[g];
			assign mif.rdAddr = s.head[g];
			assign memRd[g]   = mif.rdData;
			hfpa_fifo_mem #(
				.W  (DW),
				.AW (AW)
			) uMem (
				.mclk (mclk),
				.port (mif)
			);
		end
	endgenerate

	assign hostRdData  = s.rdData;
	assign hostRdValid = s.rdValid;
	assign txDataOut   = s.txOut;
	assign txDataValid = s.txValid;
	assign rxDataLevel = s.cnt[hfpa_pkg::FIFO_RXD];
	assign rxStsLevel  = s.cnt[hfpa_pkg::FIFO_RXS];
	assign txStsLevel  = s.cnt[hfpa_pkg::FIFO_TXS];
	assign txDataLevel = s.cnt[hfpa_pkg::FIFO_TXD];
endmodule : hfpa_top

// File: pkg/hfpa_pkg.sv
package hfpa_pkg;
	// widths and default geometry
	localparam int DATA_W  = 32;
	localparam int FIFO_AW = 4;

	// byte offsets on the host port
	localparam logic [7:0] OFF_RXD_LO   = 8'h00;
	localparam logic [7:0] OFF_RXD_HI   = 8'h1C;
	localparam logic [7:0] OFF_TXD_LO   = 8'h20;
	localparam logic [7:0] OFF_TXD_HI   = 8'h3C;
	localparam logic [7:0] OFF_RXS_POP  = 8'h40;
	localparam logic [7:0] OFF_RXS_NONDESTRUCTIVE_VIEW_PORT = 8'h44;
	localparam logic [7:0] OFF_TXS_POP  = 8'h48;
	localparam logic [7:0] OFF_TXS_NONDESTRUCTIVE_VIEW_PORT = 8'h4C;
	localparam logic [7:0] OFF_CAP      = 8'h50;
	localparam logic [7:0] OFF_CFG      = 8'h54;
	localparam logic [7:0] OFF_EVT      = 8'h58;
	localparam logic [7:0] OFF_LVL      = 8'h5C;

	// fifo numbering
	localparam logic [1:0] FIFO_RXD = 2'h0;
	localparam logic [1:0] FIFO_RXS = 2'h1;
	localparam logic [1:0] FIFO_TXS = 2'h2;
	localparam logic [1:0] FIFO_TXD = 2'h3;

	// capacity register fields
	localparam int CAP_RXD_POS = 0;
	localparam int CAP_RXS_POS = 8;
	localparam int CAP_TXD_POS = 16;

	// configuration register fields
	localparam int         CFG_MODE16_BIT = 0;
	localparam int         CFG_SWRST_BIT  = 1;
	localparam logic       CFG_MODE16_RST = 1'b0;

	// event register fields
	localparam int         EVT_RX_UNDER  = 0;
	localparam int         EVT_TX_OVER   = 1;
	localparam int         EVT_RX_OVER   = 2;
	localparam int         EVT_STS_FULL  = 8;
	localparam int         EVT_TX_SPACE  = 9;
	localparam int         EVT_DROP_POS  = 24;
	localparam logic       EVT_SPACE_RST = 1'b1;
	localparam logic [7:0] DROP_MAX      = 8'hFF;

	// level register fields
	localparam int LVL_RXD_POS = 0;
	localparam int LVL_RXS_POS = 8;
	localparam int LVL_TXS_POS = 16;
	localparam int LVL_TXD_POS = 24;

	// half-word lanes for 16-bit mode
	localparam logic [31:0] MASK_ALL = 32'hFFFFFFFF;
	localparam logic [31:0] MASK_LO  = 32'h0000FFFF;
	localparam logic [31:0] MASK_HI  = 32'hFFFF0000;

	typedef enum logic {
		SRC_REG,
		SRC_MEM
	} hfpa_src_t;
endpackage : hfpa_pkg

// File: pkg/hfpa_mem_if.sv
`timescale 1ns/10ps
interface hfpa_mem_if #(
	parameter int W  = 32,
	parameter int AW = 4
);
	logic          wrEn;
	logic [AW-1:0] wrAddr;
	logic [W-1:0]  wrData;
	logic [AW-1:0] rdAddr;
	logic [W-1:0]  rdData;

	modport mem (
		input  wrEn,
		input  wrAddr,
		input  wrData,
		input  rdAddr,
		output rdData
	);
	modport ctl (
		output wrEn,
		output wrAddr,
		output wrData,
		output rdAddr,
		input  rdData
	);
endinterface : hfpa_mem_if

// File: logic/hfpa_fifo_mem.sv
`timescale 1ns/10ps
module hfpa_fifo_mem #(
	parameter int W  = 32,
	parameter int AW = 4
) (
	// clock
	input wire logic mclk,
	// storage port
	hfpa_mem_if.mem  port
);
	typedef struct packed {
		logic [(1<<AW)-1:0][W-1:0] cells;
		logic [W-1:0]              rdData;
	} hfpa_mem_state_t;

	hfpa_mem_state_t s;
	hfpa_mem_state_t n;

	// read returns the cell as it stood before this edge's write
	always_comb begin
		n = s;
		if (port.wrEn)
			n.cells[port.wrAddr] = port.wrData;
		n.rdData = s.cells[port.rdAddr];
	end

	always_ff @(posedge mclk) begin
		s <= n;
	end

	assign port.rdData = s.rdData;
endmodule : hfpa_fifo_mem

// File: sim/hfpa_top_props.sv
`timescale 1ns/10ps
module hfpa_top_props #(
	parameter int AW = 4
) (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        softRstReq,
	// host port
	input wire logic [7:0]  hostAddr,
	input wire logic        hostRd,
	input wire logic        hostWr,
	input wire logic [31:0] hostWrData,
	input wire logic [31:0] hostRdData,
	input wire logic        hostRdValid,
	// datapath side
	input wire logic        rxDataPush,
	input wire logic        rxStsPush,
	input wire logic        txStsPush,
	input wire logic        txDataPop,
	input wire logic [AW:0] rxDataLevel,
	input wire logic [AW:0] rxStsLevel,
	input wire logic [AW:0] txStsLevel,
	input wire logic [AW:0] txDataLevel
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	logic mode16_q;
	wire  wrOk = hostWr && !hostRd;
	wire  rxdA = hostAddr <= 8'h1C;
	wire  txdA = hostAddr >= 8'h20 && hostAddr <= 8'h3C;
	// mode bit survives soft reset, so only rst_n clears the copy
	always_ff @(posedge mclk) begin
		if (!rst_n)
			mode16_q <= 1'b0;
		else if (wrOk && hostAddr == 8'h54)
			mode16_q <= hostWrData[0];
	end
	a_read_answer: assert property (hostRd |-> ##2 hostRdValid)
		else $error("read not answered two cycles later");
	a_valid_cause: assert property (hostRdValid |-> $past(hostRd, 2))
		else $error("read answer without a read");
	a_wo_zero: assert property (hostRd && txdA |-> ##2 hostRdData == 32'h0)
		else $error("write-only port read nonzero");
	a_ro_ignore: assert property (wrOk && rxdA && !rxDataPush && !softRstReq
		|=> $stable(rxDataLevel)) else $error("write moved receive data fifo");
	a_rxd_pop: assert property (hostRd && rxdA && !mode16_q && rxDataLevel != 0
		&& !rxDataPush && !softRstReq |=> rxDataLevel == $past(rxDataLevel) - 1'b1)
		else $error("receive data alias did not pop once");
	a_rxs_pop: assert property (hostRd && hostAddr == 8'h40 && rxStsLevel != 0
		&& !rxStsPush && !softRstReq |=> rxStsLevel == $past(rxStsLevel) - 1'b1)
		else $error("receive status pop did not remove one");
	a_rxs_nondestructive_view_port: assert property (hostRd && hostAddr == 8'h44 && !rxStsPush
		&& !softRstReq |=> $stable(rxStsLevel)) else $error("rx view changed fifo");
	a_txs_nondestructive_view_port: assert property (hostRd && hostAddr == 8'h4C && !txStsPush
		&& !softRstReq |=> $stable(txStsLevel)) else $error("tx view changed fifo");
	a_empty_pop: assert property (hostRd && hostAddr == 8'h48 && txStsLevel == 0
		&& !txStsPush |=> txStsLevel == 0 ##1 hostRdData == 32'h0)
		else $error("empty pop moved pointers or returned data");
	a_txd_cause: assert property (txDataLevel > $past(txDataLevel)
		|-> $past(wrOk && txdA)) else $error("tx data grew without a write");
	a_split_once: assert property (mode16_q && wrOk && txdA && !hostAddr[1]
		|=> txDataLevel <= $past(txDataLevel)) else $error("low half pushed");
endmodule : hfpa_top_props
bind hfpa_top hfpa_top_props #(.AW(AW)) u_props (
	.mclk(mclk), .rst_n(rst_n), .softRstReq(softRstReq),
	.hostAddr(hostAddr), .hostRd(hostRd), .hostWr(hostWr),
	.hostWrData(hostWrData), .hostRdData(hostRdData),
	.hostRdValid(hostRdValid), .rxDataPush(rxDataPush),
	.rxStsPush(rxStsPush), .txStsPush(txStsPush), .txDataPop(txDataPop),
	.rxDataLevel(rxDataLevel), .rxStsLevel(rxStsLevel),
	.txStsLevel(txStsLevel), .txDataLevel(txDataLevel)
);

// File: sim/hfpa_host_model.sv
`timescale 1ns/10ps
module hfpa_host_model (
	// clock
	input  wire logic        mclk,
	// host port
	output logic      [7:0]  hostAddr,
	output logic             hostRd,
	output logic             hostWr,
	output logic      [31:0] hostWrData,
	input  wire logic [31:0] hostRdData,
	input  wire logic        hostRdValid
);
	initial begin
		hostAddr = 8'h00;
		hostRd = 1'b0;
		hostWr = 1'b0;
		hostWrData = 32'h0;
	end
	// only mapped offsets, reserved fields zero
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hostAddr <= a;
		hostWr <= 1'b1;
		hostWrData <= d;
		@(posedge mclk);
		hostWr <= 1'b0;
		// released lines show the inverse so stale data cannot pass
		hostWrData <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic ok);
		ok = 1'b0;
		d = 32'h0;
		@(posedge mclk);
		hostAddr <= a;
		hostRd <= 1'b1;
		@(posedge mclk);
		hostRd <= 1'b0;
		repeat (4) begin
			@(posedge mclk);
			if (!ok && hostRdValid === 1'b1) begin
				d = hostRdData;
				ok = 1'b1;
			end
		end
	endtask : rd
endmodule : hfpa_host_model

// File: sim/host_fifo_port_access_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
	checked++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
	end \
end
module host_fifo_port_access_tb;
	localparam int AW = 4;
	logic        mclk, rst_n, softRstReq, hostRd, hostWr, hostRdValid;
	logic [7:0]  hostAddr;
	logic [31:0] hostWrData, hostRdData, rxDataIn, rxStsIn, txStsIn;
	logic        rxDataPush, rxStsPush, txStsPush, txDataPop, txDataValid;
	logic [31:0] txDataOut, d, e0, e1, w[8];
	logic [AW:0] rxDataLevel, rxStsLevel, txStsLevel, txDataLevel;
	logic [15:0] lo, hi;
	logic [7:0]  b;
	logic [31:0] seed = 32'h4C116211;
	int          n_mismatch = 0;
	int          checked = 0;
	hfpa_top #(.AW(AW)) uut (
		.mclk(mclk), .rst_n(rst_n), .softRstReq(softRstReq),
		.hostAddr(hostAddr), .hostRd(hostRd), .hostWr(hostWr),
		.hostWrData(hostWrData), .hostRdData(hostRdData),
		.hostRdValid(hostRdValid), .rxDataPush(rxDataPush),
		.rxDataIn(rxDataIn), .rxStsPush(rxStsPush), .rxStsIn(rxStsIn),
		.txStsPush(txStsPush), .txStsIn(txStsIn), .txDataPop(txDataPop),
		.txDataOut(txDataOut), .txDataValid(txDataValid),
		.rxDataLevel(rxDataLevel), .rxStsLevel(rxStsLevel),
		.txStsLevel(txStsLevel), .txDataLevel(txDataLevel)
	);
	hfpa_host_model host (
		.mclk(mclk), .hostAddr(hostAddr), .hostRd(hostRd),
		.hostWr(hostWr), .hostWrData(hostWrData),
		.hostRdData(hostRdData), .hostRdValid(hostRdValid)
	);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic        k;
		host.rd(a, v, k);
		if (k !== 1'b1) begin
			n_mismatch++;
			wrap_up();
		end
		`CHK(v, e)
	endtask : rc
	task automatic dp(input logic [1:0] s, input logic [31:0] v);
		@(posedge mclk);
		rxDataPush <= s == 2'h0;
		rxStsPush <= s == 2'h1;
		txStsPush <= s == 2'h2;
		{rxDataIn, rxStsIn, txStsIn} <= {v, v, v};
		@(posedge mclk);
		{rxDataPush, rxStsPush, txStsPush} <= 3'h0;
	endtask : dp
	task automatic pop(output logic [31:0] v);
		v = 32'h0;
		@(posedge mclk);
		txDataPop <= 1'b1;
		@(posedge mclk);
		txDataPop <= 1'b0;
		repeat (5) begin
			@(posedge mclk);
			if (txDataValid === 1'b1) begin
				v = txDataOut;
				return;
			end
		end
		n_mismatch++;
		wrap_up();
	endtask : pop
	task automatic tdone(input string s);
		$display("test %0s done", s);
	endtask : tdone
	initial begin
		{rst_n, softRstReq, rxDataPush, rxStsPush, txStsPush} = 5'h0;
		{txDataPop, rxDataIn, rxStsIn, txStsIn} = 97'h0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		`CHK(rxDataLevel | txDataLevel, 5'h0)
		rc(8'h58, 32'h00000200);
		rc(8'h50, 32'h00101010);
		rc(8'h60, 32'h0);
		tdone("reset");
		for (int i = 0; i < 8; i++) begin
			w[i] = rnd();
			dp(2'h0, w[i]);
		end
		host.wr(8'h04, rnd());
		for (int i = 0; i < 8; i++)
			rc(8'(i * 4), w[i]);
		rc(8'h1C, 32'h0);
		rc(8'h58, 32'h00000201);
		host.wr(8'h58, 32'h0);
		rc(8'h58, 32'h00000201);
		host.wr(8'h58, 32'h1);
		rc(8'h58, 32'h00000200);
		tdone("rx data");
		for (int k = 0; k < 2; k++) begin
			b = k ? 8'h48 : 8'h40;
			e0 = rnd();
			e1 = rnd();
			dp(k ? 2'h2 : 2'h1, e0);
			dp(k ? 2'h2 : 2'h1, e1);
			rc(b + 8'h4, e0);
			rc(b + 8'h4, e0);
			`CHK(k ? txStsLevel : rxStsLevel, 5'h2)
			rc(b, e0);
			rc(b + 8'h4, e1);
			rc(b, e1);
			rc(b, 32'h0);
		end
		host.wr(8'h58, 32'h1);
		tdone("status");
		for (int i = 0; i < 3; i++) begin
			w[i] = rnd();
			host.wr(i == 0 ? 8'h20 : (i == 1 ? 8'h3C : 8'h2C), w[i]);
		end
		rc(8'h3C, 32'h0);
		`CHK(txDataLevel, 5'h3)
		rc(8'h5C, 32'h03000000);
		for (int i = 0; i < 3; i++) begin
			pop(d);
			`CHK(d, w[i])
		end
		tdone("tx data");
		// data caps 0 drop all, rx status cap 1 trips the high latch
		host.wr(8'h50, 32'h00000100);
		rc(8'h50, 32'h00000100);
		host.wr(8'h20, rnd());
		repeat (3) dp(2'h0, rnd());
		`CHK(rxDataLevel | txDataLevel, 5'h0)
		e0 = rnd();
		dp(2'h1, e0);
		rc(8'h40, e0);
		// space returns, but the low latch must hold until read
		host.wr(8'h50, 32'h00100100);
		rc(8'h58, 32'h03000106);
		rc(8'h58, 32'h00000206);
		host.wr(8'h58, 32'h6);
		tdone("events");
		host.wr(8'h54, 32'h1);
		@(posedge mclk);
		softRstReq <= 1'b1;
		@(posedge mclk);
		softRstReq <= 1'b0;
		rc(8'h50, 32'h00001010);
		rc(8'h54, 32'h00000001);
		{hi, lo} = rnd();
		host.wr(8'h20, {16'h0, lo});
		@(posedge mclk);
		`CHK(txDataLevel, 5'h0)
		host.wr(8'h22, {16'h0, hi});
		@(posedge mclk);
		`CHK(txDataLevel, 5'h1)
		pop(d);
		`CHK(d, {hi, lo})
		e0 = rnd();
		e1 = rnd();
		dp(2'h0, e0);
		dp(2'h0, e1);
		rc(8'h00, {16'h0, e0[15:0]});
		rc(8'h1E, {16'h0, e0[31:16]});
		`CHK(rxDataLevel, 5'h1)
		host.wr(8'h54, 32'h3);
		@(posedge mclk);
		`CHK(rxDataLevel, 5'h0)
		rc(8'h54, 32'h1);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rc(8'h54, 32'h0);
		tdone("resets");
		wrap_up();
	end
endmodule : host_fifo_port_access_tb
